// >>> design/rsfc_defs.svh
/*
 * Offsets, field positions, reset values and timing of the codec.
 * Assumes inclusion by bare name.
 */
`ifndef RSFC_DEFS_SVH
`define RSFC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RSFC_OFS_CMD_ONE     12'h000
`define RSFC_OFS_CMD_TWO     12'h004
`define RSFC_OFS_CMD_THREE   12'h008
`define RSFC_OFS_RX_STATUS   12'h00C
`define RSFC_OFS_RX_DATA     12'h010
`define RSFC_OFS_TX_STATUS   12'h014
`define RSFC_OFS_TX_DATA     12'h018
`define RSFC_OFS_SYS_CLOCK   12'h01C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSFC_CMD3_RX_EN      0
`define RSFC_CMD3_TX_EN      1
`define RSFC_CMD3_IRQ_EN_LO  2
`define RSFC_CMD3_IRQ_MEM_LO 5
`define RSFC_RXS_BUSY        0
`define RSFC_RXS_READY       1
`define RSFC_RXS_FULL        2
`define RSFC_RXS_OVR         3
`define RSFC_TXS_FULL        0
`define RSFC_TXS_OVR         1
`define RSFC_TXS_EMPTY       2
`define RSFC_TXS_HALT        3
`define RSFC_IRQ_START       0
`define RSFC_IRQ_BYTE        1
`define RSFC_IRQ_FULL        2

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RSFC_RST_CMD_ONE     6'h00
`define RSFC_RST_CMD_TWO     5'h00
`define RSFC_FIFO_DEPTH      4
`define RSFC_CHIP_SUBDIV     13'h0010

`endif

// >>> design/rsfc_pkg.sv
/*
 * Types shared by the codec modules.
 * Assumes numeric constants live in rsfc_defs.svh.
 */
package rsfc_pkg;

   typedef logic [7:0] rsfc_byte_t;

   typedef enum logic [2:0] {
      RSFC_NRZ_LEVEL,
      RSFC_NRZ_MARK,
      RSFC_NRZ_SPACE,
      RSFC_BIPH_LEVEL,
      RSFC_BIPH_MARK,
      RSFC_BIPH_SPACE,
      RSFC_MILLER_A,
      RSFC_MILLER_B
   } rsfc_code_e;

   typedef enum logic {
      RSFC_TX_IDLE,
      RSFC_TX_SHIFT
   } rsfc_txst_e;

endpackage : rsfc_pkg

// >>> design/rsfc_baud_div.sv
/*
 * Chip-rate divider: source ticks divided by fine * coarse * 16.
 * Assumes src_tick_i is a one-cycle pulse on clk_i.
 */
`timescale 1ns/1ps
`include "rsfc_defs.svh"

module rsfc_baud_div
   import rsfc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Divider control
   input  wire logic       src_tick_i,
   input  wire logic [3:0] fine_i,
   input  wire logic [1:0] coarse_i,
   // Ticks
   output logic            chip_tick_o,
   output logic            mid_tick_o
);

   logic [12:0] cnt_r;
   logic [12:0] limit;

   function automatic logic [12:0] coarse_mult(input logic [1:0] c);
      case (c)
         2'h0:    coarse_mult = 13'h0001;
         2'h1:    coarse_mult = 13'h0004;
         2'h2:    coarse_mult = 13'h0008;
         default: coarse_mult = 13'h0010;
      endcase
   endfunction : coarse_mult

   function automatic logic [12:0] div_limit(input logic [3:0] f, input logic [1:0] c);
      logic [12:0] fv;
      fv = {9'h000, f} + 13'h0001;
      div_limit = 13'(fv * coarse_mult(c) * `RSFC_CHIP_SUBDIV) - 13'h0001;
   endfunction : div_limit

   assign limit = div_limit(fine_i, coarse_i); // [R21] [R22]

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cnt_r       <= 13'h0000;
         chip_tick_o <= 1'b0;
         mid_tick_o  <= 1'b0;
      end
      else
      begin
         chip_tick_o <= src_tick_i && (cnt_r >= limit);
         mid_tick_o  <= src_tick_i && (cnt_r == (limit >> 1));
         if (src_tick_i)
         begin
            if (cnt_r >= limit)
               cnt_r <= 13'h0000;
            else
               cnt_r <= cnt_r + 13'h0001;
         end
      end
   end

endmodule : rsfc_baud_div

// >>> design/rsfc_top.sv
/*
 * Codec data path: receive and transmit FIFOs and shifters, line
 * encoder, bit clock output, APB register slave.
 * Assumes decoder bits and start pulses come synchronous to clk_i;
 * ext_clk_i is sampled on clk_i.
 */
`timescale 1ns/1ps
`include "rsfc_defs.svh"

// Overview of operation
// [R1] Eight decoded bits form a byte for the four-byte receive FIFO.
// [R2] Receive-busy reads one while a byte is partly shifted in.
// [R3] Receive-ready reads one while the receive FIFO holds any byte.
// [R4] Full flag at four bytes; a byte arriving while full is lost, sets overrun.
// [R5] Writing one to receive overrun clears it and empties the receive FIFO.
// [R6] Start detection clears receive overrun and empties the receive FIFO.
// [R7] First received bit of a byte lands in bit zero.
// [R8] One receive interrupt from enabled sources: start, new byte, FIFO full.
// [R9] Sticky source bits record fired sources; write one clears.
// [R10] Disabling transmit lets the current shifter byte finish first.
// [R11] Transmit full flag; writing while full sets transmit overrun.
// [R12] Write one to transmit overrun: clears it, empties transmit FIFO.
// [R13] Transmit empty sets when the last FIFO byte enters the shifter.
// [R14] After the last bit with nothing queued, halted sets; pin keeps level.
// [R15] Transmit bytes leave bit zero first.
// [R16] Transmit interrupt pulses when the last FIFO byte enters the shifter.
// [R17] Coding disabled: shifter output drives the serial pin directly.
// [R18] Code select picks NRZ, bi-phase or Miller variant.
// [R19] Coding enable change applies from the next byte loaded.
// [R20] Bit clock output when enabled and data uncoded or NRZ.
// [R21] Chip rate is source over fine times coarse times sixteen; the code first halves an external clock source.
// [R22] Fine divides by code plus one; coarse by 1, 4, 8, 16.
// [R23] Reception active when receive enabled and transmit disabled.
// [R24] Radio delivers serial data on the receive data pin.
// [R25] Reading receive data returns and removes the oldest byte.
module rsfc_top
   import rsfc_pkg::*;
#(
   parameter int DEPTH = `RSFC_FIFO_DEPTH
)
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Clock source and decoder side
   input  wire logic        ext_clk_i,
   input  wire logic        dec_bit_i,
   input  wire logic        dec_valid_i,
   input  wire logic        start_det_i,
   // Radio pins and interrupts
   output logic             serial_out_pin_o,
   output logic             bitclock_out_pin_o,
   output logic             rx_irq_o,
   output logic             tx_irq_o
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   // ----------------------------------------------------------------
   // Registers and wires
   // ----------------------------------------------------------------
   logic [3:0]     baud_fine_div_r;
   logic [1:0]     baud_coarse_div_r;
   logic           line_coding_enable_r;
   logic [2:0]     line_code_select_r;
   logic           tx_bitclock_enable_r;
   logic           rx_mode_enable_r;
   logic           tx_mode_enable_r;
   logic [2:0]     rx_irq_source_enable_r;
   logic [2:0]     rx_irq_source_memory_r;
   logic           external_clock_select_r;
   logic           rx_queue_overrun_r;
   logic           tx_queue_overrun_r;
   logic           tx_queue_empty_r;
   logic           tx_halted_flag_r;
   rsfc_byte_t     rx_mem [DEPTH];
   rsfc_byte_t     tx_mem [DEPTH];
   logic [PW-1:0]  rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
   logic [CW-1:0]  rx_cnt_r, tx_cnt_r;
   rsfc_byte_t     rx_shift_r;
   logic [3:0]     rx_bits_r;
   rsfc_txst_e     tx_state_r;
   rsfc_byte_t     tx_shift_r;
   logic [2:0]     tx_bit_r;
   logic           tx_phase_r;
   logic           tx_coded_r;
   logic           tx_prev_bit_r;
   logic           bclk_live_r;
   logic           ext_q_r, ext_half_r, src_tick_r;
   logic           chip_tick, mid_tick;
   logic           wr_acc, rd_acc;
   logic           rx_active, tx_active;
   logic           rx_push, rx_pop, rx_flush, rx_lost;
   logic           tx_push, tx_pop, tx_flush;
   logic           tx_last_chip, tx_done;
   logic [2:0]     mem_set;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction : ptr_inc

   function automatic logic two_chip(input logic coded, input logic [2:0] code);
      two_chip = coded && (code >= 3'h3);
   endfunction : two_chip

   // Pin level for one chip
   function automatic logic encode(input logic coded, input logic [2:0] code,
                                   input logic b, input logic ph,
                                   input logic cur, input logic prevb);
      if (!coded)
         encode = b; // [R17]
      else
         case (rsfc_code_e'(code)) // [R18]
            RSFC_NRZ_LEVEL:  encode = b;
            RSFC_NRZ_MARK:   encode = b ? ~cur : cur;
            RSFC_NRZ_SPACE:  encode = b ? cur : ~cur;
            RSFC_BIPH_LEVEL: encode = ph ? ~b : b;
            RSFC_BIPH_MARK:  encode = (!ph || b) ? ~cur : cur;
            RSFC_BIPH_SPACE: encode = (!ph || !b) ? ~cur : cur;
            default:         encode = ph ? (b ? ~cur : cur) : ((!b && !prevb) ? ~cur : cur);
         endcase
   endfunction : encode

   // ----------------------------------------------------------------
   // Clock source and chip-rate divider
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         ext_q_r    <= 1'b0;
         ext_half_r <= 1'b0;
         src_tick_r <= 1'b0;
      end
      else
      begin
         ext_q_r <= ext_clk_i;
         if (ext_clk_i && !ext_q_r)
            ext_half_r <= ~ext_half_r;
         src_tick_r <= external_clock_select_r ? (ext_clk_i && !ext_q_r && ext_half_r)
                                               : 1'b1; // [R21]
      end
   end

   rsfc_baud_div u_baud (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .src_tick_i  (src_tick_r),
      .fine_i      (baud_fine_div_r),
      .coarse_i    (baud_coarse_div_r),
      .chip_tick_o (chip_tick),
      .mid_tick_o  (mid_tick)
   );

   // ----------------------------------------------------------------
   // APB handshake and decode
   // ----------------------------------------------------------------
   assign wr_acc    = psel_i && penable_i && pready_o && pwrite_i;
   assign rd_acc    = psel_i && penable_i && pready_o && !pwrite_i;
   assign rx_active = rx_mode_enable_r && !tx_mode_enable_r; // [R23]
   assign tx_active = tx_mode_enable_r && !rx_mode_enable_r;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end
      else if (psel_i && !penable_i && !pready_o)
      begin
         pready_o  <= 1'b1;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         if (paddr_i == `RSFC_OFS_CMD_ONE)
            prdata_o <= {26'h0, baud_coarse_div_r, baud_fine_div_r};
         else if (paddr_i == `RSFC_OFS_CMD_TWO)
            prdata_o <= {27'h0, tx_bitclock_enable_r, line_code_select_r,
                         line_coding_enable_r};
         else if (paddr_i == `RSFC_OFS_CMD_THREE)
            prdata_o <= {24'h0, rx_irq_source_memory_r, rx_irq_source_enable_r,
                         tx_mode_enable_r, rx_mode_enable_r};
         else if (paddr_i == `RSFC_OFS_RX_STATUS)
            prdata_o <= {28'h0, rx_queue_overrun_r, rx_cnt_r == FULL_CNT, // [R4]
                         rx_cnt_r != '0, // [R3]
                         rx_active && (rx_bits_r != 4'h0)}; // [R2]
         else if (paddr_i == `RSFC_OFS_RX_DATA)
            prdata_o <= {24'h0, (rx_cnt_r != '0) ? rx_mem[rx_rp_r] : 8'h00}; // [R25]
         else if (paddr_i == `RSFC_OFS_TX_STATUS)
            prdata_o <= {28'h0, tx_halted_flag_r, tx_queue_empty_r, tx_queue_overrun_r,
                         tx_cnt_r == FULL_CNT}; // [R11]
         else if (paddr_i == `RSFC_OFS_TX_DATA)
            prdata_o <= 32'h0000_0000;
         else if (paddr_i == `RSFC_OFS_SYS_CLOCK)
            prdata_o <= {31'h0, external_clock_select_r};
         else
            pslverr_o <= 1'b1;
      end
      else
      begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         {baud_coarse_div_r, baud_fine_div_r} <= `RSFC_RST_CMD_ONE;
         {tx_bitclock_enable_r, line_code_select_r, line_coding_enable_r} <= `RSFC_RST_CMD_TWO;
         rx_mode_enable_r        <= 1'b0;
         tx_mode_enable_r        <= 1'b0;
         rx_irq_source_enable_r  <= 3'h0;
         external_clock_select_r <= 1'b0;
      end
      else if (wr_acc)
      begin
         if (paddr_i == `RSFC_OFS_CMD_ONE)
            {baud_coarse_div_r, baud_fine_div_r} <= pwdata_i[5:0];
         else if (paddr_i == `RSFC_OFS_CMD_TWO)
            {tx_bitclock_enable_r, line_code_select_r, line_coding_enable_r} <= pwdata_i[4:0];
         else if (paddr_i == `RSFC_OFS_CMD_THREE)
         begin
            rx_mode_enable_r       <= pwdata_i[`RSFC_CMD3_RX_EN];
            tx_mode_enable_r       <= pwdata_i[`RSFC_CMD3_TX_EN];
            rx_irq_source_enable_r <= pwdata_i[`RSFC_CMD3_IRQ_EN_LO +: 3];
         end
         else if (paddr_i == `RSFC_OFS_SYS_CLOCK)
            external_clock_select_r <= pwdata_i[0];
      end
   end

   // ----------------------------------------------------------------
   // Receive shifter and FIFO
   // ----------------------------------------------------------------
   assign rx_push  = rx_active && dec_valid_i && (rx_bits_r == 4'h7) && !start_det_i;
   assign rx_lost  = rx_push && (rx_cnt_r == FULL_CNT) && !rx_flush;
   assign rx_pop   = rd_acc && (paddr_i == `RSFC_OFS_RX_DATA) && (rx_cnt_r != '0);
   assign rx_flush = start_det_i || (wr_acc && (paddr_i == `RSFC_OFS_RX_STATUS) &&
                     pwdata_i[`RSFC_RXS_OVR]); // [R5] [R6]

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         rx_shift_r <= 8'h00;
         rx_bits_r  <= 4'h0;
      end
      else if (start_det_i || !rx_active)
         rx_bits_r <= 4'h0;
      else if (dec_valid_i)
      begin
         rx_shift_r[rx_bits_r[2:0]] <= dec_bit_i; // [R7]
         rx_bits_r <= (rx_bits_r == 4'h7) ? 4'h0 : rx_bits_r + 4'h1; // [R1]
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         rx_wp_r            <= '0;
         rx_rp_r            <= '0;
         rx_cnt_r           <= '0;
         rx_queue_overrun_r <= 1'b0;
      end
      else if (rx_flush)
      begin
         rx_wp_r            <= '0;
         rx_rp_r            <= '0;
         rx_cnt_r           <= '0;
         rx_queue_overrun_r <= 1'b0;
      end
      else
      begin
         if (rx_lost)
            rx_queue_overrun_r <= 1'b1; // [R4]
         if (rx_push && !rx_lost)
         begin
            rx_mem[rx_wp_r] <= {dec_bit_i, rx_shift_r[6:0]}; // [R1] [R7]
            rx_wp_r         <= ptr_inc(rx_wp_r);
         end
         if (rx_pop)
            rx_rp_r <= ptr_inc(rx_rp_r); // [R25]
         rx_cnt_r <= rx_cnt_r + CW'(rx_push && !rx_lost) - CW'(rx_pop);
      end
   end

   // ----------------------------------------------------------------
   // Receive interrupt sources
   // ----------------------------------------------------------------
   assign mem_set[`RSFC_IRQ_START] = start_det_i;
   assign mem_set[`RSFC_IRQ_BYTE]  = rx_push && !rx_lost && !rx_flush;
   assign mem_set[`RSFC_IRQ_FULL]  = mem_set[`RSFC_IRQ_BYTE] && !rx_pop &&
                                     (rx_cnt_r == FULL_CNT - CW'(1));

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         rx_irq_source_memory_r <= 3'h0;
         rx_irq_o               <= 1'b0;
      end
      else
      begin
         if (wr_acc && (paddr_i == `RSFC_OFS_CMD_THREE))
            rx_irq_source_memory_r <= (rx_irq_source_memory_r &
                                       ~pwdata_i[`RSFC_CMD3_IRQ_MEM_LO +: 3]) | mem_set; // [R9]
         else
            rx_irq_source_memory_r <= rx_irq_source_memory_r | mem_set; // [R9]
         rx_irq_o <= |(rx_irq_source_memory_r & rx_irq_source_enable_r); // [R8]
      end
   end

   // ----------------------------------------------------------------
   // Transmit FIFO
   // ----------------------------------------------------------------
   assign tx_push  = wr_acc && (paddr_i == `RSFC_OFS_TX_DATA) && (tx_cnt_r != FULL_CNT);
   assign tx_flush = wr_acc && (paddr_i == `RSFC_OFS_TX_STATUS) && pwdata_i[`RSFC_TXS_OVR];
   assign tx_last_chip = chip_tick && (tx_state_r == RSFC_TX_SHIFT) &&
                         (tx_phase_r || !two_chip(tx_coded_r, line_code_select_r));
   assign tx_done  = tx_last_chip && (tx_bit_r == 3'h7);
   assign tx_pop   = tx_active && (tx_cnt_r != '0) && !tx_flush &&
                     ((tx_state_r == RSFC_TX_IDLE) || tx_done); // [R10]

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         tx_wp_r            <= '0;
         tx_rp_r            <= '0;
         tx_cnt_r           <= '0;
         tx_queue_overrun_r <= 1'b0;
      end
      else
      begin
         if (tx_flush)
         begin
            tx_wp_r  <= '0;
            tx_rp_r  <= '0;
            tx_cnt_r <= '0;
         end
         else
         begin
            if (tx_push)
            begin
               tx_mem[tx_wp_r] <= pwdata_i[7:0];
               tx_wp_r         <= ptr_inc(tx_wp_r);
            end
            if (tx_pop)
               tx_rp_r <= ptr_inc(tx_rp_r);
            tx_cnt_r <= tx_cnt_r + CW'(tx_push) - CW'(tx_pop);
         end
         if (wr_acc && (paddr_i == `RSFC_OFS_TX_DATA) && (tx_cnt_r == FULL_CNT))
            tx_queue_overrun_r <= 1'b1; // [R11]
         else if (tx_flush)
            tx_queue_overrun_r <= 1'b0; // [R12]
      end
   end

   // ----------------------------------------------------------------
   // Transmit shifter, encoder and bit clock
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         tx_state_r         <= RSFC_TX_IDLE;
         tx_shift_r         <= 8'h00;
         tx_bit_r           <= 3'h0;
         tx_phase_r         <= 1'b0;
         tx_coded_r         <= 1'b0;
         tx_prev_bit_r      <= 1'b0;
         serial_out_pin_o   <= 1'b0;
         bitclock_out_pin_o <= 1'b0;
         tx_queue_empty_r   <= 1'b1;
         tx_halted_flag_r   <= 1'b1;
         tx_irq_o           <= 1'b0;
         bclk_live_r        <= 1'b0;
      end
      else
      begin
         tx_irq_o <= tx_pop && (tx_cnt_r == CW'(1)) && !tx_push; // [R16]
         if (tx_flush || (tx_pop && (tx_cnt_r == CW'(1)) && !tx_push))
            tx_queue_empty_r <= 1'b1; // [R13]
         else if (tx_push)
            tx_queue_empty_r <= 1'b0;
         if (tx_done && !tx_pop && (tx_cnt_r == '0) && !tx_push)
            tx_halted_flag_r <= 1'b1; // [R14]
         else if (tx_push || tx_pop)
            tx_halted_flag_r <= 1'b0;
         if (tx_state_r == RSFC_TX_SHIFT && chip_tick)
         begin
            serial_out_pin_o <= encode(tx_coded_r, line_code_select_r,
                                       tx_shift_r[tx_bit_r], tx_phase_r,
                                       serial_out_pin_o, tx_prev_bit_r); // [R15] [R18]
            tx_phase_r       <= !tx_last_chip;
            if (tx_last_chip)
            begin
               tx_prev_bit_r <= tx_shift_r[tx_bit_r];
               tx_bit_r      <= tx_bit_r + 3'h1;
            end
         end
         if (tx_pop)
         begin
            tx_state_r <= RSFC_TX_SHIFT;
            tx_shift_r <= tx_mem[tx_rp_r];
            tx_bit_r   <= 3'h0;
            tx_phase_r <= 1'b0;
            tx_coded_r <= line_coding_enable_r; // [R19]
         end
         else if (tx_done)
            tx_state_r <= RSFC_TX_IDLE; // [R10] [R14]
         if (chip_tick)
            bclk_live_r <= (tx_state_r == RSFC_TX_SHIFT);
         if (!tx_bitclock_enable_r || !bclk_live_r ||
             (tx_coded_r && line_code_select_r >= 3'h3))
            bitclock_out_pin_o <= 1'b0;
         else if (chip_tick)
            bitclock_out_pin_o <= 1'b0; // [R20]
         else if (mid_tick)
            bitclock_out_pin_o <= 1'b1; // [R20]
      end
   end

endmodule : rsfc_top

// >>> tb/rsfc_top_chk.sv
/* Port checker of rsfc_top.
   Assumes binding to rsfc_top, one clock. */
`timescale 1ns/1ps
module rsfc_top_chk (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic [11:0] paddr_i,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        serial_out_pin_o,
   input wire logic        bitclock_out_pin_o,
   input wire logic        rx_irq_o,
   input wire logic        tx_irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_pready_next: assert property (psel_i && !penable_i |=> pready_o)
      else $error("pready late");
   a_pready_single: assert property (pready_o |=> !pready_o)
      else $error("pready held");
   a_err_with_ready: assert property (pslverr_o |-> pready_o)
      else $error("lone pslverr");
   a_err_unmapped: assert property (psel_i && !penable_i && paddr_i > 12'h01C |=> pslverr_o)
      else $error("no pslverr");
   a_ok_mapped: assert property (psel_i && !penable_i && paddr_i < 12'h020 &&
      paddr_i[1:0] == 2'h0 |=> !pslverr_o)
      else $error("bad pslverr");
   a_txirq_pulse: assert property (tx_irq_o |=> !tx_irq_o)
      else $error("tx irq held");
   a_bitclk_width: assert property ($rose(bitclock_out_pin_o) |-> bitclock_out_pin_o[*4])
      else $error("bit clock short");
   a_reset_quiet: assert property (disable iff (1'b0)
      !rst_n_i |=> !pready_o && !tx_irq_o && !rx_irq_o && !serial_out_pin_o)
      else $error("reset not quiet");
endmodule : rsfc_top_chk

bind rsfc_top rsfc_top_chk rsfc_top_chk_inst (.clk_i, .rst_n_i, .psel_i, .penable_i, .paddr_i,
   .pready_o, .pslverr_o, .serial_out_pin_o, .bitclock_out_pin_o, .rx_irq_o, .tx_irq_o);

// >>> tb/rsfc_radio_model.sv
/* Radio side: feeds decoded bits, captures sent bits on bit clock.
   Assumes task calls right after a rising edge. */
`timescale 1ns/1ps
module rsfc_radio_model (
   input  wire logic clk_i,
   input  wire logic serial_out_pin_i,
   input  wire logic bitclock_i,
   output logic       dec_bit_o = 1'b0,
   output logic       dec_valid_o = 1'b0,
   output logic       start_det_o = 1'b0,
   output logic [7:0] cap_word_o = 8'h00,
   output int         cap_cnt_o = 0,
   output int         cap_gap_o = 0
);
   int   gap = 0;
   logic bc_q = 1'b0;
   always @(posedge clk_i)
   begin
      bc_q <= bitclock_i;
      gap  <= gap + 1;
      if (bitclock_i && !bc_q)
      begin
         cap_word_o <= {serial_out_pin_i, cap_word_o[7:1]};
         cap_cnt_o  <= cap_cnt_o + 1;
         cap_gap_o  <= gap + 1;
         gap        <= 0;
      end
   end
   task automatic send_bits(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk_i); dec_bit_o <= b[i]; dec_valid_o <= 1'b1;
         @(posedge clk_i); dec_valid_o <= 1'b0; dec_bit_o <= ~b[i];
      end
   endtask : send_bits
   task automatic pulse_start();
      @(posedge clk_i); start_det_o <= 1'b1;
      @(posedge clk_i); start_det_o <= 1'b0;
   endtask : pulse_start
endmodule : rsfc_radio_model

// >>> tb/tb.sv
/* Bench of rsfc_top over APB and radio model.
   Assumes 16-cycle chips at divider 0. */
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_count++; \
   $display("unexpected %s exp %0h got %0h", n, e, a); end end
module tb;
   import rsfc_pkg::*;
   logic        clk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, ext_clk = 0, er;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, q, prdata;
   logic        pready, perr, sout, bclk, rxirq, txirq, dbit, dval, sdet;
   logic [7:0]  cw;
   logic [5:0]  cfgs[3] = '{6'h00, 6'h01, 6'h10};
   int          ccnt, cgap, err_count = 0, tests_run = 0, txp = 0, c0, p0;
   rsfc_byte_t  exp_q[$], b;
   initial forever #50 clk_i = ~clk_i;
   rsfc_top rsfc_top_inst (.clk_i, .rst_n_i, .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(perr), .ext_clk_i(ext_clk), .dec_bit_i(dbit), .dec_valid_i(dval),
      .start_det_i(sdet), .serial_out_pin_o(sout), .bitclock_out_pin_o(bclk),
      .rx_irq_o(rxirq), .tx_irq_o(txirq));
   rsfc_radio_model rsfc_radio_model_inst (.clk_i, .serial_out_pin_i(sout),
      .bitclock_i(bclk), .dec_bit_o(dbit), .dec_valid_o(dval), .start_det_o(sdet),
      .cap_word_o(cw), .cap_cnt_o(ccnt), .cap_gap_o(cgap));
   always @(posedge clk_i) if (txirq === 1'b1) txp <= txp + 1;
   task end_of_test();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk_i); pen <= 1;
      do begin @(posedge clk_i); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin err_count++; end_of_test(); end
      q = prdata; er = perr; psel <= 0; pen <= 0;
      @(posedge clk_i);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(0, a, 0);
      `CHK(nm, e, q)
   endtask : rd
   task automatic feed(input logic [7:0] v, input int k);
      rsfc_radio_model_inst.send_bits(v, k);
   endtask : feed
   task automatic waitcap(input int t);
      int n = 0;
      while (ccnt < t && n < 2000) begin @(posedge clk_i); n++; end
      if (n >= 2000) begin err_count++; end_of_test(); end
   endtask : waitcap
   function automatic int chip_len(input logic [5:0] c);
      int k[4] = '{1, 4, 8, 16};
      return (c[3:0] + 1) * k[c[5:4]] * 16;
   endfunction : chip_len
   initial
   begin
      void'($urandom(47));
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1;
      rd(12'h000, 32'h0, "cmd one");
      apb(0, 12'h040, 0);
      `CHK("slverr", 1'b1, er)
      $display("test regs done");
      apb(1, 12'h008, 32'h09);
      for (int i = 0; i < 5; i++)
      begin
         b = $urandom;
         if (i < 4) exp_q.push_back(b);
         feed(b, 8);
      end
      repeat (2) @(posedge clk_i);
      `CHK("rx irq", 1'b1, rxirq)
      rd(12'h00C, 32'hE, "rx full");
      rd(12'h008, 32'hC9, "irq mem");
      repeat (4) rd(12'h010, {24'h0, exp_q.pop_front()}, "rx byte");
      rd(12'h00C, 32'h8, "rx ovr");
      apb(1, 12'h00C, 32'h8);
      rd(12'h00C, 32'h0, "rx clear");
      apb(1, 12'h008, 32'hE1);
      repeat (2) @(posedge clk_i);
      `CHK("rx irq off", 1'b0, rxirq)
      feed(8'($urandom), 8);
      feed(8'h5A, 3);
      rd(12'h00C, 32'h3, "rx busy");
      rsfc_radio_model_inst.pulse_start();
      rd(12'h00C, 32'h0, "rx start");
      rd(12'h008, 32'h61, "start mem");
      apb(1, 12'h008, 32'h03);
      feed(8'($urandom), 8);
      rd(12'h00C, 32'h0, "rx gated");
      $display("test rx done");
      apb(1, 12'h008, 32'h00);
      repeat (4) apb(1, 12'h018, $urandom);
      apb(0, 12'h014, 0);
      `CHK("tx full", 3'h1, q[2:0])
      apb(1, 12'h018, $urandom);
      apb(0, 12'h014, 0);
      `CHK("tx ovr", 3'h3, q[2:0])
      apb(1, 12'h014, 32'h2);
      apb(0, 12'h014, 0);
      `CHK("tx flush", 3'h4, q[2:0])
      apb(1, 12'h004, 32'h10);
      apb(1, 12'h008, 32'h02);
      foreach (cfgs[i])
      begin
         apb(1, 12'h000, {26'h0, cfgs[i]});
         b = $urandom;
         c0 = ccnt;
         p0 = txp;
         apb(1, 12'h018, {24'h0, b});
         waitcap(c0 + 8);
         `CHK("tx byte", b, cw)
         `CHK("chip len", chip_len(cfgs[i]), cgap)
         repeat (chip_len(cfgs[i])) @(posedge clk_i);
         apb(0, 12'h014, 0);
         `CHK("tx halt", 4'hC, q[3:0])
         `CHK("tx irq", p0 + 1, txp)
      end
      $display("test tx done");
      end_of_test();
   end
endmodule : tb
